// *** verilog/vdc_params.svh ***
`ifndef VDC_PARAMS_SVH
`define VDC_PARAMS_SVH

// short i/o address modifiers
`define VDC_AM_SUP_SIO      6'h2d
`define VDC_AM_NPRIV_SIO    6'h29

// location offsets inside the board's space
`define VDC_CH_FIRST_OFS    16'h0060
`define VDC_CH_LAST_OFS     16'h006e
`define VDC_CSR_OFS         16'h0070
`define VDC_FACTORY_BASE    16'h0060
`define VDC_LOCAL_MSB       4

// control and status word fields
`define VDC_CSR_UPDATE_BIT  0
`define VDC_CSR_PEND_BIT    1
`define VDC_CSR_DEFER_BIT   2
`define VDC_CSR_EXT_BIT     3
`define VDC_CSR_TWOS_BIT    4
`define VDC_CSR_NPRIV_BIT   5
`define VDC_CSR_CTRL_MSB    15
`define VDC_CSR_CTRL_LSB    8

// reset values
`define VDC_CH_RST          16'h0000
`define VDC_DAC_RST         16'h8000
`define VDC_CTRL_RST        8'h00

// timing: synchroniser depth on every pin
`define VDC_SYNC_STAGES     2

`endif

// *** verilog/vdc_pkg.sv ***
package vdc_pkg;

  typedef enum logic [1:0] {
    VDC_IDLE   = 2'b00,
    VDC_ACCESS = 2'b01,
    VDC_ACK    = 2'b11
  } vdc_bus_state_t;

  typedef enum logic {
    VDC_OFFSET_BIN = 1'b0,
    VDC_TWOS_COMP  = 1'b1
  } vdc_coding_t;

  typedef enum logic [1:0] {
    VDC_UPD_IMMEDIATE = 2'b00,
    VDC_UPD_PROGRAM   = 2'b01,
    VDC_UPD_EXTERNAL  = 2'b11
  } vdc_update_mode_t;

endpackage : vdc_pkg

// *** verilog/vdc_sync2.sv ***
`timescale 1ns/1ps
`default_nettype none

module vdc_sync2 #(
  parameter int          W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_sys_rst,
  // asynchronous in, synchronised out
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // first stage is read only by the second
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;

endmodule : vdc_sync2

`default_nettype wire

// *** verilog/vdc_config_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "vdc_params.svh"

// Notes on behaviour
// - low switches give expected A07..A05
// - high switches give expected A15..A08
// - switch on matches zero, off matches one
// - any address mismatch leaves board unselected
// - A00..A04 are zero, select locations
// - factory switches give base 0060 hex
// - only short i/o modifiers are decoded
// - no jumper: supervisory short i/o only
// - jumper fitted: non-privileged short i/o instead
// - coding jumpers pick offset binary or two's
// - default coding is offset binary
// - deferred jumper without trigger jumper: outputs wait for update command
// - no deferred jumper: writes update outputs directly
// - external trigger needs deferred jumper too
// - external trigger buffered before use
// - two latch stages per channel
// - eight channel words at 0060..006e
// - control and status word at 0070
// - one strobe updates all eight channels
module vdc_config_decode #(
  parameter int NCH = 8,
  parameter int DW  = 16
) (
  // clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_sys_rst,
  // vmebus slave, short i/o
  input  wire logic              i_as_n,
  input  wire logic              i_ds0_n,
  input  wire logic              i_ds1_n,
  input  wire logic              i_write_n,
  input  wire logic              i_iack_n,
  input  wire logic [15:1]       i_addr,
  input  wire logic [5:0]        i_am,
  input  wire logic [DW-1:0]     i_data,
  output logic      [DW-1:0]     o_data,
  output logic                   o_data_oe,
  output logic                   o_dtack_n,
  output logic                   o_dtack_oe,
  // second connector trigger
  input  wire logic              i_ext_trigger,
  // switches, 1 = on (closed)
  input  wire logic [3:0]        i_base_addr_low_switches,
  input  wire logic [7:0]        i_base_addr_high_switches,
  // jumpers, 1 = fitted
  input  wire logic              i_offset_binary_jumper,
  input  wire logic              i_twos_complement_jumper,
  input  wire logic              i_nonpriv_access_jumper,
  input  wire logic              i_deferred_update_jumper,
  input  wire logic              i_external_trigger_jumper,
  // converter side
  output logic      [NCH*DW-1:0] o_dac_code,
  output logic                   o_dac_load,
  output logic      [7:0]        o_ctrl_word,
  output logic      [15:0]       o_base_addr,
  output logic      [1:0]        o_update_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  localparam int PW = 60;
  localparam logic [PW-1:0] PIN_RST = {5'h1f, 55'h0};

  logic [PW-1:0] pins_async;
  logic [PW-1:0] pins_s;

  assign pins_async = {i_as_n, i_ds1_n, i_ds0_n, i_write_n, i_iack_n,
                       i_addr, i_am, i_data, i_ext_trigger,
                       i_base_addr_low_switches, i_base_addr_high_switches,
                       i_offset_binary_jumper, i_twos_complement_jumper,
                       i_nonpriv_access_jumper, i_deferred_update_jumper,
                       i_external_trigger_jumper};

  vdc_sync2 #(
    .W       (PW),
    .RST_VAL (PIN_RST)
  ) u_pin_sync (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_async   (pins_async),
    .o_sync    (pins_s)
  );

  wire       as_n_s     = pins_s[59];
  wire       ds1_n_s    = pins_s[58];
  wire       ds0_n_s    = pins_s[57];
  wire       write_n_s  = pins_s[56];
  wire       iack_n_s   = pins_s[55];
  wire [15:1] addr_s    = pins_s[54:40];
  wire [5:0] am_s       = pins_s[39:34];
  wire [15:0] data_s    = pins_s[33:18];
  wire       trig_s     = pins_s[17];
  wire [3:0] sw_low_s   = pins_s[16:13];
  wire [7:0] sw_high_s  = pins_s[12:5];
  wire       j_ofs_s    = pins_s[4];
  wire       j_twos_s   = pins_s[3];
  wire       j_npriv_s  = pins_s[2];
  wire       j_defer_s  = pins_s[1];
  wire       j_ext_s    = pins_s[0];

  ////////////////////////////////////////////////////////////////////////////
  // configuration from jumpers

  wire twos_sel = j_twos_s && !j_ofs_s;
  wire vdc_pkg::vdc_coding_t coding =
    twos_sel ? vdc_pkg::VDC_TWOS_COMP : vdc_pkg::VDC_OFFSET_BIN;
  wire ext_mode   = j_defer_s && j_ext_s;
  wire vdc_pkg::vdc_update_mode_t upd_mode =
    !j_defer_s ? vdc_pkg::VDC_UPD_IMMEDIATE :
    ext_mode   ? vdc_pkg::VDC_UPD_EXTERNAL  :
                 vdc_pkg::VDC_UPD_PROGRAM;

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  // on (1) expects a zero, off (0) expects a one
  wire [15:5] base_expect = {~sw_high_s, ~sw_low_s[2:0]};
  wire [15:0] base_addr   = {base_expect, 5'h00};
  wire        base_hit    = (addr_s[15:5] == base_expect);

  wire [5:0] am_expect = j_npriv_s ? `VDC_AM_NPRIV_SIO
                                   : `VDC_AM_SUP_SIO;
  wire       am_hit    = (am_s == am_expect);

  wire [4:0] local_ofs = {addr_s[4:1], 1'b0};
  wire [4:0] ch_first  = 5'(`VDC_CH_FIRST_OFS);
  wire [4:0] ch_last   = 5'(`VDC_CH_LAST_OFS);
  wire [4:0] csr_ofs   = 5'(`VDC_CSR_OFS);
  wire       ch_hit    = (local_ofs >= ch_first) && (local_ofs <= ch_last);
  wire       csr_hit   = (local_ofs == csr_ofs);
  wire [2:0] ch_idx    = addr_s[3:1];

  wire strobe   = !as_n_s && (!ds0_n_s || !ds1_n_s) && iack_n_s;
  wire selected = strobe && base_hit && am_hit && (ch_hit || csr_hit);

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake

  vdc_pkg::vdc_bus_state_t state_ff;
  vdc_pkg::vdc_bus_state_t nxt_state;

  wire ds_released = ds0_n_s && ds1_n_s;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      vdc_pkg::VDC_IDLE: begin
        if (selected) begin
          nxt_state = vdc_pkg::VDC_ACCESS;
        end
      end
      vdc_pkg::VDC_ACCESS: begin
        nxt_state = vdc_pkg::VDC_ACK;
      end
      vdc_pkg::VDC_ACK: begin
        if (ds_released) begin
          nxt_state = vdc_pkg::VDC_IDLE;
        end
      end
      default: begin
        nxt_state = vdc_pkg::VDC_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      state_ff <= vdc_pkg::VDC_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // one write per cycle: only in the access state
  wire in_access = (state_ff == vdc_pkg::VDC_ACCESS);
  wire wr_en     = in_access && !write_n_s;
  wire rd_en     = in_access && write_n_s;
  wire [1:0] lanes = {!ds1_n_s, !ds0_n_s};

  ////////////////////////////////////////////////////////////////////////////
  // channel latches

  logic [DW-1:0] first_ff  [NCH];
  logic [DW-1:0] second_ff [NCH];
  logic [7:0]    ctrl_ff;
  logic          pend_ff;
  logic          trig_d_ff;
  logic          load_ff;

  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old,
                                          input logic [DW-1:0] wd,
                                          input logic [1:0]    be);
    merge = {be[1] ? wd[DW-1:8] : old[DW-1:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : merge

  // msb flip turns two's complement into offset binary
  function automatic logic [DW-1:0] to_dac(input logic [DW-1:0] v,
                                           input logic           twos);
    to_dac = twos ? {~v[DW-1], v[DW-2:0]} : v;
  endfunction : to_dac

  wire ch_wr   = wr_en && ch_hit;
  wire csr_wr  = wr_en && csr_hit;
  wire upd_cmd = csr_wr && lanes[0] && data_s[`VDC_CSR_UPDATE_BIT];
  wire trig_rise = trig_s && !trig_d_ff;

  // program mode uses the command, external mode only the strobe
  wire xfer_all =
    ((upd_mode == vdc_pkg::VDC_UPD_PROGRAM) && upd_cmd) ||
    ((upd_mode == vdc_pkg::VDC_UPD_EXTERNAL) && trig_rise);
  wire immediate = (upd_mode == vdc_pkg::VDC_UPD_IMMEDIATE);

  wire [DW-1:0] ch_wdata = merge(first_ff[ch_idx], data_s, lanes);

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      wire this_wr = ch_wr && (ch_idx == 3'(g));

      always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
          first_ff[g] <= `VDC_CH_RST;
        end else if (this_wr) begin
          first_ff[g] <= ch_wdata;
        end
      end

      // second stage drives the converter
      always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
          second_ff[g] <= `VDC_DAC_RST;
        end else if (immediate && this_wr) begin
          second_ff[g] <= to_dac(ch_wdata, coding == vdc_pkg::VDC_TWOS_COMP);
        end else if (xfer_all) begin
          second_ff[g] <= to_dac(first_ff[g], coding == vdc_pkg::VDC_TWOS_COMP);
        end
      end

      assign o_dac_code[g*DW +: DW] = second_ff[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // control word, pending flag, trigger edge

  // a write in the transfer cycle keeps pending set
  wire pend_set = ch_wr && !immediate;
  wire pend_clr = xfer_all;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      ctrl_ff   <= `VDC_CTRL_RST;
      pend_ff   <= 1'b0;
      trig_d_ff <= 1'b0;
      load_ff   <= 1'b0;
    end else begin
      if (csr_wr && lanes[1]) begin
        ctrl_ff <= data_s[`VDC_CSR_CTRL_MSB:`VDC_CSR_CTRL_LSB];
      end
      pend_ff   <= pend_set || (pend_ff && !pend_clr);
      trig_d_ff <= trig_s;
      load_ff   <= xfer_all || (immediate && ch_wr);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data and bus drivers

  logic [DW-1:0] status_word;

  always_comb begin
    status_word = '0;
    status_word[`VDC_CSR_CTRL_MSB:`VDC_CSR_CTRL_LSB] = ctrl_ff;
    status_word[`VDC_CSR_PEND_BIT]  = pend_ff;
    status_word[`VDC_CSR_DEFER_BIT] = j_defer_s;
    status_word[`VDC_CSR_EXT_BIT]   = ext_mode;
    status_word[`VDC_CSR_TWOS_BIT]  = twos_sel;
    status_word[`VDC_CSR_NPRIV_BIT] = j_npriv_s;
  end

  wire [DW-1:0] rd_word = csr_hit ? status_word : first_ff[ch_idx];

  logic [DW-1:0] rdata_ff;
  logic          rd_oe_ff;
  logic          ack_ff;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      rdata_ff <= '0;
      rd_oe_ff <= 1'b0;
      ack_ff   <= 1'b0;
    end else begin
      if (rd_en) begin
        rdata_ff <= rd_word;
      end
      rd_oe_ff <= (rd_en || rd_oe_ff) && (nxt_state == vdc_pkg::VDC_ACK);
      ack_ff   <= (nxt_state == vdc_pkg::VDC_ACK);
    end
  end

  assign o_data        = rdata_ff;
  assign o_data_oe     = rd_oe_ff;
  assign o_dtack_n     = !ack_ff;
  assign o_dtack_oe    = ack_ff;
  assign o_dac_load    = load_ff;
  assign o_ctrl_word   = ctrl_ff;
  assign o_base_addr   = base_addr;
  assign o_update_mode = upd_mode;

endmodule : vdc_config_decode

`default_nettype wire

// *** verif/vdc_config_decode_props.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "vdc_params.svh"
module vdc_config_decode_props #(
  parameter int NCH = 8,
  parameter int DW  = 16
) (
  // clock and reset
  input wire logic              i_mclk,
  input wire logic              i_sys_rst,
  // bus pins
  input wire logic              i_as_n,
  input wire logic              i_ds0_n,
  input wire logic              i_ds1_n,
  input wire logic              i_write_n,
  input wire logic              i_iack_n,
  input wire logic [15:1]       i_addr,
  input wire logic [5:0]        i_am,
  // switches and jumpers
  input wire logic [3:0]        i_base_addr_low_switches,
  input wire logic [7:0]        i_base_addr_high_switches,
  input wire logic              i_nonpriv_access_jumper,
  input wire logic              i_deferred_update_jumper,
  input wire logic              i_external_trigger_jumper,
  // board outputs
  input wire logic              o_dtack_n,
  input wire logic              o_dtack_oe,
  input wire logic              o_data_oe,
  input wire logic [NCH*DW-1:0] o_dac_code,
  input wire logic              o_dac_load,
  input wire logic [15:0]       o_base_addr,
  input wire logic [1:0]        o_update_mode
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  wire logic [10:0] exp_hi = ~{i_base_addr_high_switches, i_base_addr_low_switches[2:0]};
  wire logic [14:0] cfg = {i_base_addr_high_switches, i_base_addr_low_switches,
                           i_deferred_update_jumper, i_external_trigger_jumper, 1'b0};
  // synced pins hold reset values for two edges after reset lets go
  logic [1:0] settle_ff;
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      settle_ff <= 2'h0;
    end else if (!settle_ff[1]) begin
      settle_ff <= settle_ff + 2'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  property p_reset_idle;
    disable iff (1'b0) i_sys_rst |=> o_dtack_n && !o_dtack_oe && !o_data_oe &&
      !o_dac_load && o_dac_code == {NCH{`VDC_DAC_RST}};
  endproperty
  property p_addr_match;
    $rose(o_dtack_oe) |-> i_addr[15:5] == exp_hi;
  endproperty
  property p_am_match;
    $rose(o_dtack_oe) |-> i_am == (i_nonpriv_access_jumper ? `VDC_AM_NPRIV_SIO : `VDC_AM_SUP_SIO);
  endproperty
  property p_strobes;
    $rose(o_dtack_oe) |-> !i_as_n && i_iack_n && !(i_ds0_n && i_ds1_n);
  endproperty
  property p_read_drive;
    o_data_oe |-> o_dtack_oe && !o_dtack_n && i_write_n;
  endproperty
  property p_release;
    (i_ds0_n && i_ds1_n) [*4] |-> !o_dtack_oe && !o_data_oe;
  endproperty
  property p_load_follows;
    !$stable(o_dac_code) |-> o_dac_load ##1 !o_dac_load;
  endproperty
  // switches are slow pins: judge only once they have sat still
  property p_base;
    (settle_ff[1] && $stable(cfg)) [*4] |-> o_base_addr == {exp_hi, 5'h00};
  endproperty
  property p_mode;
    (settle_ff[1] && $stable(cfg)) [*4] |-> o_update_mode == (i_deferred_update_jumper ?
      (i_external_trigger_jumper ? 2'b11 : 2'b01) : 2'b00);
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("bad reset state");
  a_addr_match: assert property (p_addr_match) else $error("wrong address taken");
  a_am_match: assert property (p_am_match) else $error("wrong modifier taken");
  a_strobes: assert property (p_strobes) else $error("taken without strobes");
  a_read_drive: assert property (p_read_drive) else $error("data driven off read");
  a_release: assert property (p_release) else $error("acknowledge held");
  a_load_follows: assert property (p_load_follows) else $error("load pulse wrong");
  a_base: assert property (p_base) else $error("base address wrong");
  a_mode: assert property (p_mode) else $error("update mode wrong");
  c_write: cover property ($rose(o_dtack_oe) && !i_write_n);
  c_read: cover property ($rose(o_dtack_oe) && i_write_n);
  c_ext: cover property (o_dac_load && o_update_mode == 2'b11);
endmodule : vdc_config_decode_props
bind vdc_config_decode vdc_config_decode_props #(.NCH(NCH), .DW(DW)) u_props (.*);
`default_nettype wire

// *** verif/vdc_vme_master.sv ***
`timescale 1ns/1ps
`default_nettype none
module vdc_vme_master (
  // clock and board answer
  input  wire logic        i_mclk,
  input  wire logic        i_dtack_n,
  input  wire logic [15:0] i_data,
  // master side of the bus
  output logic             o_as_n,
  output logic             o_ds_n,
  output logic             o_write_n,
  output logic             o_iack_n,
  output logic [15:1]      o_addr,
  output logic [5:0]       o_am,
  output logic [15:0]      o_data,
  output logic             o_trig
);
  initial begin
    {o_as_n, o_ds_n, o_write_n, o_iack_n, o_trig} = 5'h1e;
    o_addr = '0;
    o_am = '0;
    o_data = 16'h0;
  end
  // a refused cycle is given up after a bounded wait
  task automatic cycle(input logic [15:0] a, input logic [5:0] am, input logic wr,
                       input logic [15:0] wd, input logic iack,
                       output logic [15:0] rd, output logic ok);
    int n;
    ok = 1'b0;
    n = 0;
    rd = 16'h0;
    @(posedge i_mclk);
    o_addr <= a[15:1];
    o_am <= am;
    o_write_n <= !wr;
    o_iack_n <= iack;
    o_data <= wr ? wd : ~o_data;
    o_as_n <= 1'b0;
    o_ds_n <= 1'b0;
    while (!ok && n < 12) begin
      @(posedge i_mclk);
      ok = (i_dtack_n === 1'b0);
      rd = i_data;
      n++;
    end
    o_as_n <= 1'b1;
    o_ds_n <= 1'b1;
    o_iack_n <= 1'b1;
    o_data <= ~o_data;
    repeat (6) @(posedge i_mclk);
  endtask : cycle
  task automatic pulse;
    @(posedge i_mclk);
    o_trig <= 1'b1;
    repeat (4) @(posedge i_mclk);
    o_trig <= 1'b0;
    repeat (6) @(posedge i_mclk);
  endtask : pulse
endmodule : vdc_vme_master
`default_nettype wire

// *** verif/tb_vdc_config_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_vdc_config_decode;
  logic i_mclk = 1'b0, i_sys_rst = 1'b1;
  wire logic i_as_n, i_ds0_n, i_ds1_n, i_write_n, i_iack_n, i_ext_trigger, o_dtack_n, o_dtack_oe;
  wire logic [15:1] i_addr;
  wire logic [5:0] i_am;
  wire logic [15:0] i_data, m_data, o_data, o_base_addr;
  wire logic o_data_oe, o_dac_load;
  wire logic [127:0] o_dac_code;
  wire logic [7:0] o_ctrl_word;
  wire logic [1:0] o_update_mode;
  logic [3:0] i_base_addr_low_switches = 4'h4;
  logic [7:0] i_base_addr_high_switches = 8'hff;
  logic i_offset_binary_jumper = 1'b1, i_twos_complement_jumper = 1'b0;
  logic i_nonpriv_access_jumper = 1'b0, i_deferred_update_jumper = 1'b0;
  logic i_external_trigger_jumper = 1'b0;
  int error_cnt = 0, cmp_count = 0;
  logic [5:0] am = 6'h2d;
  logic [15:0] rdv;
  logic ok;
  // open-drain acknowledge idles high; data bus is whoever drives it
  wire logic dtack_w = o_dtack_oe ? o_dtack_n : 1'b1;
  assign i_data = o_data_oe ? o_data : m_data;
  assign i_ds1_n = i_ds0_n;
  always #5 i_mclk = ~i_mclk;
  vdc_config_decode dut (.*);
  vdc_vme_master m (.i_mclk(i_mclk), .i_dtack_n(dtack_w), .i_data(i_data), .o_as_n(i_as_n),
    .o_ds_n(i_ds0_n), .o_write_n(i_write_n), .o_iack_n(i_iack_n), .o_addr(i_addr),
    .o_am(i_am), .o_data(m_data), .o_trig(i_ext_trigger));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic [15:0] a, input logic [5:0] amv, input logic w,
                     input logic [15:0] wd, input logic iack, input logic e_ok);
    m.cycle(a, amv, w, wd, iack, rdv, ok);
    chk({15'h0, ok}, {15'h0, e_ok});
  endtask : acc
  task automatic wr(input logic [15:0] a, input logic [15:0] wd);
    acc(a, am, 1'b1, wd, 1'b1, 1'b1);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    acc(a, am, 1'b0, 16'h0, 1'b1, 1'b1);
    chk(rdv, e);
  endtask : rd
  function automatic logic [15:0] dac(input int n);
    return o_dac_code[16*n +: 16];
  endfunction : dac
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (20000) @(posedge i_mclk);
    error_cnt++;
    wrap_up();
  end
  initial begin
    repeat (3) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    repeat (4) @(posedge i_mclk);
    chk(o_base_addr, 16'h0060);
    chk(dac(0), 16'h8000);
    for (int i = 0; i < 8; i++) wr(16'h0060 + 16'(2 * i), 16'h1000 + 16'(i));
    for (int i = 0; i < 8; i++) chk(dac(i), 16'h1000 + 16'(i));
    rd(16'h0066, 16'h1003);
    wr(16'h0070, 16'h4100);
    rd(16'h0070, 16'h4100);
    chk({8'h0, o_ctrl_word}, 16'h0041);
    acc(16'h0072, am, 1'b1, 16'h0, 1'b1, 1'b0);
    acc(16'h0160, am, 1'b1, 16'h0, 1'b1, 1'b0);
    acc(16'h0040, am, 1'b1, 16'h0, 1'b1, 1'b0);
    acc(16'h0061, am, 1'b1, 16'h0, 1'b1, 1'b1);
    acc(16'h0060, 6'h29, 1'b1, 16'h0, 1'b1, 1'b0);
    acc(16'h0060, 6'h3d, 1'b1, 16'h0, 1'b1, 1'b0);
    acc(16'h0060, am, 1'b1, 16'h0, 1'b0, 1'b0);
    i_nonpriv_access_jumper <= 1'b1;
    am = 6'h29;
    repeat (4) @(posedge i_mclk);
    acc(16'h0060, 6'h2d, 1'b1, 16'h0, 1'b1, 1'b0);
    wr(16'h0060, 16'h2222);
    rd(16'h0070, 16'h4120);
    chk(dac(0), 16'h2222);
    i_nonpriv_access_jumper <= 1'b0;
    am = 6'h2d;
    i_offset_binary_jumper <= 1'b0;
    i_twos_complement_jumper <= 1'b1;
    repeat (4) @(posedge i_mclk);
    wr(16'h0062, 16'hffff);
    chk(dac(1), 16'h7fff);
    i_offset_binary_jumper <= 1'b1;
    repeat (4) @(posedge i_mclk);
    wr(16'h0062, 16'h0001);
    chk(dac(1), 16'h0001);
    i_twos_complement_jumper <= 1'b0;
    i_deferred_update_jumper <= 1'b1;
    repeat (4) @(posedge i_mclk);
    chk({14'h0, o_update_mode}, 16'h0001);
    wr(16'h0064, 16'h5555);
    m.pulse();
    chk(dac(2), 16'h1002);
    rd(16'h0070, 16'h4106);
    wr(16'h0070, 16'h4101);
    chk(dac(2), 16'h5555);
    rd(16'h0070, 16'h4104);
    i_external_trigger_jumper <= 1'b1;
    repeat (4) @(posedge i_mclk);
    chk({14'h0, o_update_mode}, 16'h0003);
    wr(16'h0066, 16'h6666);
    wr(16'h0070, 16'h4101);
    rd(16'h0070, 16'h410e);
    chk(dac(3), 16'h1003);
    m.pulse();
    chk(dac(3), 16'h6666);
    chk(dac(2), 16'h5555);
    i_deferred_update_jumper <= 1'b0;
    repeat (4) @(posedge i_mclk);
    chk({14'h0, o_update_mode}, 16'h0000);
    wr(16'h0068, 16'h7777);
    chk(dac(4), 16'h7777);
    i_base_addr_high_switches <= 8'h00;
    i_base_addr_low_switches <= 4'h8;
    repeat (4) @(posedge i_mclk);
    chk(o_base_addr, 16'hffe0);
    wr(16'hffe0, 16'h0abc);
    chk(dac(0), 16'h0abc);
    acc(16'h0060, am, 1'b1, 16'h0, 1'b1, 1'b0);
    wrap_up();
  end
endmodule : tb_vdc_config_decode
`default_nettype wire
